/* File: verif/timer16_capture_compare_pwm_bench.sv */
// self-checking bench for the 16-bit capture/compare/pwm timer
`timescale 1ns/100ps
module timer16_capture_compare_pwm_bench;
  import timer16_pkg::*;
  logic              clk;
  logic              sys_rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic              ext_pin;
  logic              cap_pin;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rd_val;
  logic              pready;
  logic              pslverr;
  logic              pin_a;
  logic              oe_a;
  logic              pin_b;
  logic              oe_b;
  logic              last;
  logic [33:0]       exp_q[$];
  logic [33:0]       e_m;
  logic [31:0]       seed;
  logic [15:0]       v;
  logic [15:0]       tp;
  logic [5:0]        tbl[8];
  int                dv[4];
  int                bad_count;
  int                samples_checked;
  int                k;
  int                n;

  timer16 #(.PADDR_WIDTH(8)) i_dut (
    .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_COUNT_PIN(ext_pin), .CAPTURE_PIN(cap_pin), .COMPARE_A_PIN(pin_a),
    .COMPARE_A_OE(oe_a), .COMPARE_B_PIN(pin_b), .COMPARE_B_OE(oe_b)
  );

  always #50 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    int w;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    if (w >= 20) begin
      bad_count++;
      give_verdict();
    end
    rd_val = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    exp_q.push_back(34'h0);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] d);
    exp_q.push_back({2'b10, 24'h000000, d});
    apb(1'b0, idx, 8'h00);
  endtask

  // read whose value is judged afterwards by range
  task automatic rdv(input logic [5:0] idx);
    exp_q.push_back(34'h0);
    apb(1'b0, idx, 8'h00);
  endtask

  // high byte first on write, low byte first on read
  task automatic wr16(input logic [5:0] lo, input logic [15:0] d);
    wr(lo + 6'h01, d[15:8]);
    wr(lo, d[7:0]);
  endtask

  task automatic rd16(input logic [5:0] lo, input logic [15:0] d);
    rd(lo, d[7:0]);
    rd(lo + 6'h01, d[15:8]);
  endtask

  // watches completions and takes the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
      end else begin
        e_m = exp_q.pop_front();
        check(e_m[33] ? {pslverr, prdata} : {pslverr, 32'h0}, e_m[32:0]);
      end
    end
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, ext_pin, cap_pin} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h6542;
    tbl = '{IDX_CAP_LOW, IDX_CAP_HIGH, IDX_CMPB_LOW, IDX_CMPB_HIGH,
            IDX_CMPA_LOW, IDX_CMPA_HIGH, IDX_CNT_LOW, IDX_CNT_HIGH};
    dv = '{8, 64, 256, 1024};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 8; k++) rd(tbl[k], 8'h00);
    exp_q.push_back({2'b11, 32'h0});
    apb(1'b0, 6'h30, 8'h00);
    // stage shared: lone high write must not touch compare A yet
    wr(IDX_CMPA_HIGH, 8'hAA);
    rd(IDX_CMPA_HIGH, 8'h00);
    wr(IDX_CMPA_LOW, 8'h55);
    rd16(IDX_CMPA_LOW, 16'hAA55);
    for (k = 0; k < 3; k++) begin
      seed = xs(seed);
      v = seed[15:0];
      wr16(IDX_CNT_LOW, v);
      rd16(IDX_CNT_LOW, v);
      seed = xs(seed);
      wr16(IDX_CMPB_LOW, seed[15:0]);
      rd16(IDX_CMPB_LOW, seed[15:0]);
    end
    // written equality with the clock stopped is no match
    wr(IDX_FLAGS, 8'h0F);
    wr16(IDX_CMPA_LOW, v);
    wr16(IDX_CNT_LOW, v);
    rd(IDX_FLAGS, 8'h00);
    // capture on the selected edge only; counter stopped so value is exact
    wr16(IDX_CNT_LOW, 16'h1234);
    @(posedge clk) cap_pin <= 1'b1;
    repeat (3) @(posedge clk);
    cap_pin <= 1'b0;
    repeat (3) @(posedge clk);
    rd16(IDX_CAP_LOW, 16'h1234);
    rd(IDX_FLAGS, 8'h08);
    wr(IDX_FLAGS, 8'h0F);
    wr16(IDX_CNT_LOW, 16'h2222);
    wr(IDX_CTRL_B, 8'h40);
    @(posedge clk) cap_pin <= 1'b1;
    repeat (3) @(posedge clk);
    wr(IDX_FLAGS, 8'h0F);
    wr16(IDX_CNT_LOW, 16'h3333);
    @(posedge clk) cap_pin <= 1'b0;
    repeat (3) @(posedge clk);
    rd16(IDX_CAP_LOW, 16'h2222);
    rd(IDX_FLAGS, 8'h00);
    // external pin, both edge codes, five pulses each
    for (k = 6; k < 8; k++) begin
      wr(IDX_CTRL_B, 8'h00);
      wr16(IDX_CNT_LOW, 16'h0000);
      wr(IDX_CTRL_B, 8'(k));
      repeat (5) begin
        @(posedge clk) ext_pin <= 1'b1;
        repeat (2) @(posedge clk);
        ext_pin <= 1'b0;
        repeat (2) @(posedge clk);
      end
      wr(IDX_CTRL_B, 8'h00);
      rd16(IDX_CNT_LOW, 16'h0005);
    end
    // prescaler phase is free, so four or five ticks in four periods
    for (k = 0; k < 4; k++) begin
      wr16(IDX_CNT_LOW, 16'h0000);
      wr(IDX_CTRL_B, 8'(k + 2));
      repeat (4 * dv[k]) @(posedge clk);
      wr(IDX_CTRL_B, 8'h00);
      rdv(IDX_CNT_LOW);
      check(33'(rd_val[7:0] >= 8'h04 && rd_val[7:0] <= 8'h05), 33'd1);
    end
    // clear on compare A at div1, then without it
    wr(IDX_FLAGS, 8'h0F);
    wr16(IDX_CMPB_LOW, 16'hFFFF);
    wr16(IDX_CMPA_LOW, 16'h0010);
    wr16(IDX_CNT_LOW, 16'h0000);
    wr(IDX_CTRL_B, 8'h09);
    repeat (200) @(posedge clk);
    wr(IDX_CTRL_B, 8'h08);
    rdv(IDX_CNT_LOW);
    check(33'(rd_val[7:0] <= 8'h10), 33'd1);
    rd(IDX_CNT_HIGH, 8'h00);
    rd(IDX_FLAGS, 8'h02);
    wr16(IDX_CNT_LOW, 16'h0000);
    wr(IDX_CTRL_B, 8'h01);
    repeat (100) @(posedge clk);
    wr(IDX_CTRL_B, 8'h00);
    rdv(IDX_CNT_LOW);
    check(33'(rd_val[7:0] > 8'h10), 33'd1);
    // pwm at 8, 9 and 10 bits, A non-inverted, B inverted; clear on compare left set
    wr(IDX_CTRL_B, 8'h09);
    for (k = 0; k < 5; k++) begin
      tp = (k < 3) ? TOP_8 : (k == 3) ? TOP_9 : TOP_10;
      v = (k == 0) ? 16'h0000 : (k == 1) ? tp : 16'h0080;
      wr(IDX_CTRL_A, 8'hB0 | 8'((k < 3) ? 1 : k - 1));
      wr16(IDX_CMPA_LOW, v);
      wr16(IDX_CMPB_LOW, v);
      rd16(IDX_CMPA_LOW, v);
      wr(IDX_FLAGS, 8'h0F);
      repeat (2 * tp + 90) @(posedge clk);
      n = 0;
      // two full periods of samples, so the toggle count is phase free
      for (int c = 0; c <= 4 * tp; c++) begin
        @(negedge clk);
        if (c > 0 && pin_a !== last) n++;
        last = pin_a;
        if (k < 2) check({pin_a, pin_b, oe_a, oe_b}, {v != 0, v == 0, 2'b11});
      end
      if (k >= 2) check(33'(n), 33'd4);
      rdv(IDX_FLAGS);
      check(33'(rd_val[0]), 33'd1);
    end
    // normal mode pins: A toggles, B sets on match; wrap sets overflow
    wr(IDX_CTRL_B, 8'h00);
    wr(IDX_CTRL_A, 8'h70);
    wr16(IDX_CMPA_LOW, 16'h0010);
    wr16(IDX_CMPB_LOW, 16'h0020);
    wr16(IDX_CNT_LOW, 16'hFFF0);
    wr(IDX_FLAGS, 8'h0F);
    last = pin_a;
    wr(IDX_CTRL_B, 8'h01);
    repeat (100) @(posedge clk);
    wr(IDX_CTRL_B, 8'h00);
    rd(IDX_FLAGS, 8'h07);
    @(negedge clk);
    check({pin_a, pin_b, oe_a, oe_b}, {!last, 3'b111});
    give_verdict();
  end
endmodule

/* File: verilog/timer16.sv */
// 16-bit timer with prescaler, two compare channels, capture and dual pwm, apb slave
//
// Behaviour
// (R1) clear-on-compare set: counter goes to zero at the next timer tick after channel A match
// (R2) clear-on-compare ignored while pwm mode runs
// (R3) three-bit clock select: stop, clk, /8, /64, /256, /1024, pin fall, pin rise
// (R4) software makes the external count pin an input
// (R5) high byte write staged, low byte write loads all 16 counter bits
// (R6) low byte read stages counter high byte, high byte read returns stage
// (R7) software writes high first, reads low first, guards the shared stage
// (R8) after a preset counting resumes from written value at next timer tick
// (R9) match only when counting reaches compare value, never from a write
// (R10) compare flag set in the cycle after the compare event
// (R11) compare high byte staged, low byte write updates both bytes together
// (R12) selected capture pin edge copies counter to capture register, sets flag
// (R13) capture low read stages high byte, high read returns stage
// (R14) pwm: counts up from zero to top then down, free running
// (R15) pwm top 255, 511 or 1023; period twice top
// (R16) pwm compares 10 low bits; mode 10 clear up set down, 11 inverse
// (R17) pwm compare writes held, latched into use when counter reaches top
// (R18) compare read returns the most recently written value
// (R19) compare at zero or top holds the pwm pin constant per mode
// (R20) pwm overflow flag set when counter turns at zero
// (R21) flags behave the same in pwm mode as in normal mode
// (R22) capture edge select: clear falling, set rising
// (R23) pwm select: 00 off, 01 8-bit, 10 9-bit, 11 10-bit
`timescale 1ns/100ps
module timer16 #(
  parameter int PADDR_WIDTH = 8
) (
  input  wire logic                           CLK,
  input  wire logic                           SYS_RST,
  input  wire logic                           PSEL,
  input  wire logic                           PENABLE,
  input  wire logic                           PWRITE,
  input  wire logic [timer16_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [timer16_pkg::DATA_W-1:0] PWDATA,
  output logic      [timer16_pkg::DATA_W-1:0] PRDATA,
  output logic                                PREADY,
  output logic                                PSLVERR,
  input  wire logic                           EXT_COUNT_PIN,
  input  wire logic                           CAPTURE_PIN,
  output logic                                COMPARE_A_PIN,
  output logic                                COMPARE_A_OE,
  output logic                                COMPARE_B_PIN,
  output logic                                COMPARE_B_OE
);
  import timer16_pkg::*;

  if (PADDR_WIDTH != ADDR_W) begin : g_bad_addr
    $error("timer16 needs an 8-bit apb address");
  end

  logic [15:0]       count_r, count_nxt;
  dir_type           dir_r, dir_nxt;
  logic              moved_r, moved_nxt;
  logic              up_r, up_nxt;
  logic              pend_r, pend_nxt;
  logic [PRE_W-1:0]  pre_r, pre_nxt;
  logic              ext_prev_r, cap_prev_r;
  logic [15:0]       cap_r, cap_nxt;
  logic [7:0]        temp_r, temp_nxt;
  logic [15:0]       cmp_wr_r [2];
  logic [15:0]       cmp_wr_nxt [2];
  logic [15:0]       cmp_act_r [2];
  logic [15:0]       cmp_act_nxt [2];
  logic [1:0]        mode_r [2];
  logic [1:0]        mode_nxt [2];
  logic [1:0]        pwm_sel_r, pwm_sel_nxt;
  logic              edge_sel_r, edge_sel_nxt;
  logic              clr_cmp_r, clr_cmp_nxt;
  logic [2:0]        clk_sel_r, clk_sel_nxt;
  logic [3:0]        flags_r, flags_nxt;
  logic [1:0]        pin_r, pin_nxt, oe_r, oe_nxt;
  logic [DATA_W-1:0] prdata_r, prdata_nxt;
  logic              pready_r, pready_nxt, pslverr_r, pslverr_nxt;

  logic        tick, pwm_on, cnt_load, cap_evt, ovf_set;
  logic [15:0] top;
  logic [1:0]  match;
  logic        first, done, wr_done, rd_first, addr_ok;
  logic [5:0]  idx;
  logic [15:0] wr_word;

  // ---- apb decode; one wait state, write side effects on completing edge, read staging on first edge ----
  assign idx      = PADDR[7:2];
  assign first    = PSEL && PENABLE && !pready_r;
  assign done     = PSEL && PENABLE && pready_r;
  assign wr_done  = done && PWRITE && !pslverr_r;
  assign rd_first = first && !PWRITE;
  assign wr_word  = {temp_r, PWDATA[7:0]};
  assign cnt_load = wr_done && idx == IDX_CNT_LOW; // [R5]

  always_comb begin
    unique case (idx)
      IDX_CAP_LOW, IDX_CAP_HIGH, IDX_CMPB_LOW, IDX_CMPB_HIGH, IDX_CMPA_LOW,
      IDX_CMPA_HIGH, IDX_CNT_LOW, IDX_CNT_HIGH, IDX_CTRL_B, IDX_CTRL_A,
      IDX_FLAGS: addr_ok = (PADDR[1:0] == 2'h0);
      default:   addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    pready_nxt  = first;
    pslverr_nxt = first && !addr_ok;
    prdata_nxt  = prdata_r;
    if (rd_first) begin
      prdata_nxt = '0;
      unique case (addr_ok ? idx : 6'h00)
        IDX_CAP_LOW:   prdata_nxt[7:0] = cap_r[7:0];
        IDX_CAP_HIGH:  prdata_nxt[7:0] = temp_r;           // [R13]
        IDX_CMPB_LOW:  prdata_nxt[7:0] = cmp_wr_r[1][7:0]; // [R18]
        IDX_CMPB_HIGH: prdata_nxt[7:0] = cmp_wr_r[1][15:8];
        IDX_CMPA_LOW:  prdata_nxt[7:0] = cmp_wr_r[0][7:0];
        IDX_CMPA_HIGH: prdata_nxt[7:0] = cmp_wr_r[0][15:8];
        IDX_CNT_LOW:   prdata_nxt[7:0] = count_r[7:0];
        IDX_CNT_HIGH:  prdata_nxt[7:0] = temp_r;           // [R6]
        IDX_CTRL_A: begin
          prdata_nxt[MODE_A_POS +: 2]  = mode_r[0];
          prdata_nxt[MODE_B_POS +: 2]  = mode_r[1];
          prdata_nxt[PWM_SEL_POS +: 2] = pwm_sel_r;
        end
        IDX_CTRL_B: begin
          prdata_nxt[EDGE_SEL_POS]     = edge_sel_r;
          prdata_nxt[CLR_CMP_POS]      = clr_cmp_r;
          prdata_nxt[CLK_SEL_POS +: 3] = clk_sel_r;
        end
        IDX_FLAGS:     prdata_nxt[3:0] = flags_r;
        default:       prdata_nxt = '0;
      endcase
    end
  end

  // ---- shared byte stage and control registers ----
  always_comb begin
    temp_nxt     = temp_r;
    mode_nxt     = mode_r;
    pwm_sel_nxt  = pwm_sel_r;
    edge_sel_nxt = edge_sel_r;
    clr_cmp_nxt  = clr_cmp_r;
    clk_sel_nxt  = clk_sel_r;
    // staging on the first access cycle keeps both bytes from one instant
    if (rd_first && addr_ok && idx == IDX_CNT_LOW) temp_nxt = count_r[15:8]; // [R6]
    if (rd_first && addr_ok && idx == IDX_CAP_LOW) temp_nxt = cap_r[15:8];   // [R13]
    if (wr_done) begin
      unique case (idx)
        IDX_CNT_HIGH, IDX_CMPA_HIGH, IDX_CMPB_HIGH: temp_nxt = PWDATA[7:0]; // [R5] [R11]
        IDX_CTRL_A: begin
          mode_nxt[0] = PWDATA[MODE_A_POS +: 2];
          mode_nxt[1] = PWDATA[MODE_B_POS +: 2];
          pwm_sel_nxt = PWDATA[PWM_SEL_POS +: 2]; // [R23]
        end
        IDX_CTRL_B: begin
          edge_sel_nxt = PWDATA[EDGE_SEL_POS];
          clr_cmp_nxt  = PWDATA[CLR_CMP_POS];
          clk_sel_nxt  = PWDATA[CLK_SEL_POS +: 3];
        end
        default: temp_nxt = temp_r;
      endcase
    end
  end

  // ---- prescaler and count source ----
  assign pre_nxt = pre_r + 1'b1;
  always_comb begin
    unique case (clk_sel_r) // [R3]
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = &pre_r[2:0];
      CS_DIV64:    tick = &pre_r[5:0];
      CS_DIV256:   tick = &pre_r[7:0];
      CS_DIV1024:  tick = &pre_r[9:0];
      CS_EXT_FALL: tick = ext_prev_r && !EXT_COUNT_PIN;
      CS_EXT_RISE: tick = !ext_prev_r && EXT_COUNT_PIN;
    endcase
  end

  // ---- counter ----
  assign pwm_on = (pwm_sel_r != 2'h0);
  always_comb begin
    unique case (pwm_sel_r) // [R15] [R23]
      2'h1:    top = TOP_8;
      2'h2:    top = TOP_9;
      2'h3:    top = TOP_10;
      default: top = CNT_MAX;
    endcase
  end

  // a write leaves moved clear, so an equal preset never matches
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      if (pwm_on) match[c] = moved_r && count_r[9:0] == cmp_act_r[c][9:0]; // [R9] [R16]
      else        match[c] = moved_r && count_r == cmp_act_r[c];           // [R9]
    end
  end

  always_comb begin
    count_nxt = count_r;
    dir_nxt   = dir_r;
    moved_nxt = 1'b0;
    up_nxt    = up_r;
    pend_nxt  = pend_r;
    ovf_set   = 1'b0;
    if (match[0] && clr_cmp_r && !pwm_on) pend_nxt = 1'b1; // [R1] [R2]
    if (pwm_on) pend_nxt = 1'b0;                             // [R2]
    if (cnt_load) begin
      count_nxt = wr_word; // [R5] [R8]
      pend_nxt  = 1'b0;
    end else if (tick) begin
      moved_nxt = 1'b1;
      if (pwm_on) begin
        if (dir_r == DIR_DOWN) begin
          if (count_r == 16'h0000) begin
            dir_nxt   = DIR_UP; // [R14]
            count_nxt = count_r + 16'h0001;
            up_nxt    = 1'b1;
            ovf_set   = 1'b1;   // [R20]
          end else begin
            count_nxt = count_r - 16'h0001;
            up_nxt    = 1'b0;
          end
        end else if (count_r >= top) begin
          dir_nxt   = DIR_DOWN; // [R14]
          count_nxt = count_r - 16'h0001;
          up_nxt    = 1'b0;
        end else begin
          count_nxt = count_r + 16'h0001;
          up_nxt    = 1'b1;
        end
      end else begin
        dir_nxt = DIR_UP;
        up_nxt  = 1'b1;
        if (pend_r || (match[0] && clr_cmp_r)) begin
          count_nxt = 16'h0000; // [R1]
          pend_nxt  = 1'b0;
        end else begin
          count_nxt = count_r + 16'h0001;
          ovf_set   = (count_r == CNT_MAX);
        end
      end
    end
  end

  // ---- compare registers, capture, flags, pins ----
  assign cap_evt = edge_sel_r ? (!cap_prev_r && CAPTURE_PIN)   // [R22]
                              : (cap_prev_r && !CAPTURE_PIN);
  assign cap_nxt = cap_evt ? count_r : cap_r; // [R12]

  always_comb begin
    cmp_wr_nxt  = cmp_wr_r;
    cmp_act_nxt = cmp_act_r;
    // in pwm mode the working copy changes only at top, so no odd pulse
    if (pwm_on && count_r == top) cmp_act_nxt = cmp_wr_r; // [R17]
    for (int c = 0; c < 2; c++) begin
      if (wr_done && idx == (c == 0 ? IDX_CMPA_LOW : IDX_CMPB_LOW)) begin
        cmp_wr_nxt[c] = wr_word;                  // [R11] [R18]
        if (!pwm_on) cmp_act_nxt[c] = wr_word;    // [R17]
      end
    end
  end

  always_comb begin
    logic [3:0] set_v;
    logic [3:0] clr_v;
    set_v = '0;
    clr_v = '0;
    set_v[FLAG_OVF]  = ovf_set;  // [R20] [R21]
    set_v[FLAG_CMPA] = match[0]; // [R10] [R21]
    set_v[FLAG_CMPB] = match[1]; // [R10] [R21]
    set_v[FLAG_CAP]  = cap_evt;  // [R12]
    if (wr_done && idx == IDX_FLAGS) clr_v = PWDATA[3:0];
    // a new event beats a clear arriving in the same cycle
    flags_nxt = (flags_r & ~clr_v) | set_v;
  end

  always_comb begin
    logic inv;
    logic [9:0] v;
    pin_nxt = pin_r;
    oe_nxt  = oe_r;
    inv     = 1'b0;
    v       = '0;
    for (int c = 0; c < 2; c++) begin
      inv = mode_r[c][0];
      v   = cmp_act_r[c][9:0];
      if (pwm_on) begin
        oe_nxt[c] = mode_r[c][1]; // [R16]
        if (mode_r[c][1]) begin
          if (v == 10'h000)        pin_nxt[c] = inv;             // [R19]
          else if (v == top[9:0])  pin_nxt[c] = !inv;            // [R19]
          else if (match[c])       pin_nxt[c] = up_r ? inv : !inv; // [R16]
        end
      end else begin
        oe_nxt[c] = (mode_r[c] != 2'h0);
        if (match[c]) begin
          unique case (mode_r[c])
            2'h1:    pin_nxt[c] = !pin_r[c];
            2'h2:    pin_nxt[c] = 1'b0;
            2'h3:    pin_nxt[c] = 1'b1;
            default: pin_nxt[c] = pin_r[c];
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      count_r    <= RST_WORD;
      dir_r      <= DIR_UP;
      moved_r    <= 1'b0;
      up_r       <= 1'b1;
      pend_r     <= 1'b0;
      pre_r      <= '0;
      ext_prev_r <= 1'b0;
      cap_prev_r <= 1'b0;
      cap_r      <= RST_WORD;
      temp_r     <= RST_BYTE;
      cmp_wr_r   <= '{RST_WORD, RST_WORD};
      cmp_act_r  <= '{RST_WORD, RST_WORD};
      mode_r     <= '{2'h0, 2'h0};
      pwm_sel_r  <= 2'h0;
      edge_sel_r <= 1'b0;
      clr_cmp_r  <= 1'b0;
      clk_sel_r  <= CS_STOP;
      flags_r    <= RST_FLAGS;
      pin_r      <= 2'h0;
      oe_r       <= 2'h0;
      prdata_r   <= '0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end else begin
      count_r    <= count_nxt;
      dir_r      <= dir_nxt;
      moved_r    <= moved_nxt;
      up_r       <= up_nxt;
      pend_r     <= pend_nxt;
      pre_r      <= pre_nxt;
      ext_prev_r <= EXT_COUNT_PIN;
      cap_prev_r <= CAPTURE_PIN;
      cap_r      <= cap_nxt;
      temp_r     <= temp_nxt;
      cmp_wr_r   <= cmp_wr_nxt;
      cmp_act_r  <= cmp_act_nxt;
      mode_r     <= mode_nxt;
      pwm_sel_r  <= pwm_sel_nxt;
      edge_sel_r <= edge_sel_nxt;
      clr_cmp_r  <= clr_cmp_nxt;
      clk_sel_r  <= clk_sel_nxt;
      flags_r    <= flags_nxt;
      pin_r      <= pin_nxt;
      oe_r       <= oe_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
    end
  end

  assign PRDATA        = prdata_r;
  assign PREADY        = pready_r;
  assign PSLVERR       = pslverr_r;
  assign COMPARE_A_PIN = pin_r[0];
  assign COMPARE_A_OE  = oe_r[0];
  assign COMPARE_B_PIN = pin_r[1];
  assign COMPARE_B_OE  = oe_r[1];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_clear_on_match: assert property ( // [R1]
    (!pwm_on && clr_cmp_r && match[0] && tick && !cnt_load) |=> count_r == 16'h0000)
    else $error("counter not cleared after channel a match");
  a_pwm_no_clear: assert property ( // [R2]
    (pwm_on && $past(pwm_on)) |-> !pend_r)
    else $error("clear pending while pwm runs");
  a_stop_holds: assert property ( // [R3]
    (clk_sel_r == CS_STOP && !cnt_load) |=> $stable(count_r))
    else $error("stopped counter moved");
  a_count_load: assert property ( // [R5]
    cnt_load |=> (count_r == $past(wr_word)) && !moved_r)
    else $error("counter preset wrong or flagged as counted");
  a_low_read_stage: assert property ( // [R6]
    (rd_first && idx == IDX_CNT_LOW && PADDR[1:0] == 2'h0)
      |=> temp_r == $past(count_r[15:8]) ##1 1'b1)
    else $error("counter high byte not staged");
  a_flag_follows: assert property ( // [R10]
    match[0] |=> flags_r[FLAG_CMPA])
    else $error("compare flag missing after match");
  a_capture_copy: assert property ( // [R12]
    cap_evt |=> (cap_r == $past(count_r)) && flags_r[FLAG_CAP])
    else $error("capture value or flag wrong");
  a_pwm_turn_zero: assert property ( // [R20]
    (pwm_on && tick && !cnt_load && dir_r == DIR_DOWN && count_r == 16'h0000)
      |=> flags_r[FLAG_OVF] && dir_r == DIR_UP && count_r == 16'h0001)
    else $error("pwm turn at zero wrong");
endmodule

/* File: verilog/timer16_pkg.sv */
// constants, register map and types for the 16-bit capture/compare/pwm timer
package timer16_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;
  // register indices; byte address is four times the index
  localparam logic [5:0]  IDX_CAP_LOW     = 6'h24;
  localparam logic [5:0]  IDX_CAP_HIGH    = 6'h25;
  localparam logic [5:0]  IDX_CMPB_LOW    = 6'h28;
  localparam logic [5:0]  IDX_CMPB_HIGH   = 6'h29;
  localparam logic [5:0]  IDX_CMPA_LOW    = 6'h2A;
  localparam logic [5:0]  IDX_CMPA_HIGH   = 6'h2B;
  localparam logic [5:0]  IDX_CNT_LOW     = 6'h2C;
  localparam logic [5:0]  IDX_CNT_HIGH    = 6'h2D;
  localparam logic [5:0]  IDX_CTRL_B      = 6'h2E;
  localparam logic [5:0]  IDX_CTRL_A      = 6'h2F;
  localparam logic [5:0]  IDX_FLAGS       = 6'h38;
  // control A fields
  localparam int          MODE_A_POS      = 6;
  localparam int          MODE_B_POS      = 4;
  localparam int          PWM_SEL_POS     = 0;
  // control B fields
  localparam int          EDGE_SEL_POS    = 6;
  localparam int          CLR_CMP_POS     = 3;
  localparam int          CLK_SEL_POS     = 0;
  // flag bits
  localparam int          FLAG_OVF        = 0;
  localparam int          FLAG_CMPA       = 1;
  localparam int          FLAG_CMPB       = 2;
  localparam int          FLAG_CAP        = 3;
  // reset values
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [3:0]  RST_FLAGS       = 4'h0;
  // clock select codes
  localparam logic [2:0]  CS_STOP         = 3'h0;
  localparam logic [2:0]  CS_DIV1         = 3'h1;
  localparam logic [2:0]  CS_DIV8         = 3'h2;
  localparam logic [2:0]  CS_DIV64        = 3'h3;
  localparam logic [2:0]  CS_DIV256       = 3'h4;
  localparam logic [2:0]  CS_DIV1024      = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL     = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE     = 3'h7;
  localparam int          PRE_W           = 10;
  // pwm tops
  localparam logic [15:0] TOP_8           = 16'h00FF;
  localparam logic [15:0] TOP_9           = 16'h01FF;
  localparam logic [15:0] TOP_10          = 16'h03FF;
  localparam logic [15:0] CNT_MAX         = 16'hFFFF;
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_type;
endpackage
